// ---- verilog/ext_bus_defines.svh ----
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

// Bus widths
`define EB_ADDR_W        20
`define EB_DATA_W        16
`define EB_AREAS         4

// Wait expansion field codes (two bits per area)
`define EB_EXP_ONE_WAIT  2'h0
`define EB_EXP_TWO_WAIT  2'h1
`define EB_EXP_THREE_WAIT 2'h2

// Bus cycle lengths in bus-clock periods
`define EB_SFR_CYC_FAST  3'h2
`define EB_SFR_CYC_SLOW  3'h3
`define EB_MEM_CYC_FAST  3'h1
`define EB_MEM_CYC_SLOW  3'h2
`define EB_SEP_CYC_READ0 3'h1
`define EB_SEP_CYC_WR0   3'h2
`define EB_SEP_CYC_W1    3'h2
`define EB_SEP_CYC_W2    3'h3
`define EB_SEP_CYC_W3    3'h4
`define EB_MUX_CYC_SHORT 3'h3
`define EB_MUX_CYC_LONG  3'h4

// Reset values of the wait controls
`define EB_RST_WAIT_DIS  4'h0
`define EB_RST_WAIT_EXP  8'h00
`define EB_RST_IWS       1'h0
`define EB_RST_RCS       1'h0

// Synchroniser depth for pin inputs
`define EB_SYNC_STAGES   2

`endif

// ---- verilog/ext_bus_pkg.sv ----
`default_nettype none
`include "ext_bus_defines.svh"

package ext_bus_pkg;

  // Target of one CPU access
  typedef enum logic [2:0] {
    AREA_SFR = 3'h0,
    AREA_MEM = 3'h1,
    AREA_EXT = 3'h2
  } area_e;

  // One CPU access request
  typedef struct packed {
    area_e                  area;       // Kind of target
    logic [1:0]             ext_sel;    // External chip-select area 0..3
    logic                   write;      // 1 = write, 0 = read
    logic                   byte_high;  // Upper byte taking part
    logic [`EB_ADDR_W-1:0]  addr;       // Access address
    logic [`EB_DATA_W-1:0]  wdata;      // Write data
  } bus_req_s;

  // Wait and cycle configuration
  typedef struct packed {
    logic                   internal_wait_select;
    logic                   register_cycle_select;
    logic                   multiplexed_mode;
    logic                   strobe_scheme_select;
    logic [`EB_AREAS-1:0]   chip_select_control_reg;  // Wait-disable bits, area 3..0
    logic [2*`EB_AREAS-1:0] wait_expansion_reg;       // Two bits per area
  } wait_cfg_s;

  // Pin-side outputs
  typedef struct packed {
    logic [`EB_ADDR_W-1:0]  addr;
    logic [`EB_DATA_W-1:0]  data;
    logic                   data_oe_n;
    logic                   rd_n;
    logic                   low_byte_write_strobe_n;
    logic                   high_byte_write_strobe_n;
    logic                   byte_high_enable_n;
    logic [`EB_AREAS-1:0]   area_selects_n;
    logic                   ale;
  } bus_pins_s;

endpackage : ext_bus_pkg

`default_nettype wire

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Asynchronous input and its synchronised copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;   // First stage, read only by the second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stage_q;  // Second stage
  logic [WIDTH-1:0] stage_d;

  // Next values of both stages
  always_comb begin
    meta_d  = async_in;
    stage_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q  <= '0;
      stage_q <= '0;
    end else begin
      meta_q  <= meta_d;
      stage_q <= stage_d;
    end
  end

  assign sync_out = stage_q;

endmodule : pin_sync

`default_nettype wire

// ---- verilog/external_bus_wait_control.sv ----
// Behaviour
// R1 - SFR drives address; internal memory holds it
// R2 - Internal reads float data; SFR writes drive
// R3 - Internal memory strobes high; selects high, latch low
// R4 - Byte-high follows SFR; held on internal memory
// R5 - SFR cycle: 2 or 3 by cycle select
// R6 - Internal memory: 1 cycle, or 2 waited
// R7 - No-wait separate area: read 1, write 2 (code reads in 2 when internal wait select is set or the field is not 00)
// R8 - Waited separate area: 2, 3, 4 cycles
// R9 - Multiplexed area: 3 or 4 cycles
// R10 - Software clears wait-disable to use wait request
// R11 - Reset clears all wait controls
// R12 - Software keeps cycle select low at fast PLL
// R13 - Software uses combined strobes on byte bus
// R14 - Waits stretch strobe; field 11 reserved
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.svh"

module external_bus_wait_control
  import ext_bus_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // Configuration load
  input  wire logic                   cfg_load,
  input  wire wait_cfg_s              cfg_in,
  output wait_cfg_s                   cfg_out,
  // CPU request side
  input  wire logic                   req_valid,
  input  wire bus_req_s               req,
  output logic                        req_ready,
  output logic                        done,
  output logic [`EB_DATA_W-1:0]       rdata,
  // Bus pins in
  input  wire logic                   bclk_pin,
  input  wire logic                   wait_req_n_pin,
  input  wire logic [`EB_DATA_W-1:0]  data_pin_in,
  // Bus pins out
  output bus_pins_s                   pins
);

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ALIGN  = 3'b010,
    ST_ACTIVE = 3'b100
  } seq_e;

  // Synchronised pin inputs
  logic                  bclk_s;     // Bus clock after two flops
  logic                  wait_req_s; // Wait request, high while the partner wants a wait
  logic [`EB_DATA_W-1:0] data_s;     // Data bus after two flops
  logic                  wait_n_s;

  pin_sync #(.WIDTH(1)) u_sync_bclk (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (bclk_pin),
    .sync_out (bclk_s)
  );

  pin_sync #(.WIDTH(1)) u_sync_wait (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (wait_req_n_pin),
    .sync_out (wait_n_s)
  );

  pin_sync #(.WIDTH(`EB_DATA_W)) u_sync_data (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (data_pin_in),
    .sync_out (data_s)
  );

  // Pin is active low; inside the block a wait is high
  assign wait_req_s = ~wait_n_s;

  // State
  seq_e                  state_q, state_d;         // Sequencer state
  logic                  bclk_prev_q, bclk_prev_d; // For edge finding
  wait_cfg_s             cfg_q, cfg_d;             // Wait controls
  bus_req_s              cur_q, cur_d;             // Access in progress
  logic [2:0]            cnt_q, cnt_d;             // Bus-clock periods elapsed
  logic [2:0]            len_q, len_d;             // Periods the access lasts
  logic                  rdy_use_q, rdy_use_d;     // Wait request honoured
  bus_pins_s             pins_q, pins_d;           // Registered pin outputs
  logic                  ready_q, ready_d;         // Request accepted when high
  logic                  done_q, done_d;           // End-of-access pulse
  logic [`EB_DATA_W-1:0] rdata_q, rdata_d;         // Captured read data

  // Rising edge of the bus clock
  logic bclk_rise;
  assign bclk_rise = bclk_s & ~bclk_prev_q;

  // Length of one access in bus-clock periods
  function automatic logic [2:0] cycle_len(input bus_req_s r, input wait_cfg_s c);
    logic       wdis;
    logic [1:0] exp;
    logic [2:0] len;
    wdis = c.chip_select_control_reg[r.ext_sel];
    exp  = c.wait_expansion_reg[2*r.ext_sel +: 2];
    // Fallback for area codes that cannot occur
    len  = `EB_SEP_CYC_W3;
    unique case (r.area)
      AREA_SFR: begin
        // Of the wait controls only the register cycle select plays a part here
        len = c.register_cycle_select ? `EB_SFR_CYC_SLOW : `EB_SFR_CYC_FAST; // R5
      end
      AREA_MEM: begin
        len = c.internal_wait_select ? `EB_MEM_CYC_SLOW : `EB_MEM_CYC_FAST; // R6
      end
      AREA_EXT: begin
        // Bus mode first, then wait-disable, then the area's field
        if (c.multiplexed_mode) begin
          // Long form only for the three-wait code and the reserved one
          len = exp[1] ? `EB_MUX_CYC_LONG : `EB_MUX_CYC_SHORT; // R9
        end else if (wdis) begin
          if (!c.internal_wait_select && exp == `EB_EXP_ONE_WAIT) begin
            len = r.write ? `EB_SEP_CYC_WR0 : `EB_SEP_CYC_READ0; // R7
          end else begin
            len = `EB_SEP_CYC_W1; // R7
          end
        end else begin
          unique case (exp)
            `EB_EXP_ONE_WAIT:   len = `EB_SEP_CYC_W1; // R8
            `EB_EXP_TWO_WAIT:   len = `EB_SEP_CYC_W2; // R8
            `EB_EXP_THREE_WAIT: len = `EB_SEP_CYC_W3; // R8
            default:            len = `EB_SEP_CYC_W3; // R14
          endcase
        end
      end
      default: len = `EB_SEP_CYC_W3;
    endcase
    return len;
  endfunction : cycle_len

  // Sequencer, configuration and pin next-state logic
  always_comb begin
    state_d     = state_q;
    bclk_prev_d = bclk_s;
    cfg_d       = cfg_q;
    cur_d       = cur_q;
    cnt_d       = cnt_q;
    len_d       = len_q;
    rdy_use_d   = rdy_use_q;
    pins_d      = pins_q;
    ready_d     = ready_q;
    done_d      = 1'b0;
    rdata_d     = rdata_q;

    // Configuration is only taken between accesses
    if (cfg_load && state_q == ST_IDLE) begin
      cfg_d = cfg_in;
    end

    // Access sequencer
    unique case (state_q)
      ST_IDLE: begin
        // Take a request, then wait for a bus-clock edge to start
        if (req_valid && ready_q) begin
          cur_d     = req;
          len_d     = cycle_len(req, cfg_q);
          // Wait request only stretches waited external areas
          rdy_use_d = (req.area == AREA_EXT) && !cfg_q.chip_select_control_reg[req.ext_sel]; // R10
          ready_d   = 1'b0;
          state_d   = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        // Pins change only on a bus-clock rise, so the access lines up with it
        if (bclk_rise) begin
          cnt_d   = 3'h1;
          state_d = ST_ACTIVE;
          unique case (cur_q.area)
            AREA_SFR: begin
              // Register access shows its address, strobes and byte-high
              pins_d.addr               = cur_q.addr; // R1
              pins_d.byte_high_enable_n = ~cur_q.byte_high; // R4
              pins_d.rd_n               = cur_q.write;
              pins_d.data               = cur_q.wdata;
              pins_d.data_oe_n          = ~cur_q.write; // R2
              pins_d.area_selects_n     = '1; // R3
              pins_d.ale                = 1'b0; // R3
              if (cur_q.write) begin
                pins_d.low_byte_write_strobe_n  = 1'b0;
                pins_d.high_byte_write_strobe_n = ~(cfg_q.strobe_scheme_select & cur_q.byte_high);
              end
            end
            AREA_MEM: begin
              // Address and byte-high keep their last values; data floats
              pins_d.data_oe_n                = 1'b1; // R2
              pins_d.rd_n                     = 1'b1; // R3
              pins_d.low_byte_write_strobe_n  = 1'b1; // R3
              pins_d.high_byte_write_strobe_n = 1'b1; // R3
              pins_d.area_selects_n           = '1; // R3
              pins_d.ale                      = 1'b0; // R3
            end
            default: begin
              // External area: full bus cycle with select and latch pulse
              pins_d.addr                         = cur_q.addr;
              pins_d.byte_high_enable_n           = ~cur_q.byte_high;
              pins_d.area_selects_n               = '1;
              pins_d.area_selects_n[cur_q.ext_sel] = 1'b0;
              pins_d.ale                          = 1'b1;
              pins_d.rd_n                         = cur_q.write;
              pins_d.data                         = cur_q.wdata;
              pins_d.data_oe_n                    = ~cur_q.write;
              if (cur_q.write) begin
                pins_d.low_byte_write_strobe_n  = 1'b0;
                pins_d.high_byte_write_strobe_n = ~(cfg_q.strobe_scheme_select & cur_q.byte_high);
              end
            end
          endcase
        end
      end
      ST_ACTIVE: begin
        if (bclk_rise) begin
          // Latch enable lasts only the first period
          pins_d.ale = 1'b0;
          if (cnt_q >= len_q && !(rdy_use_q && wait_req_s)) begin
            // End of access: release strobes and selects
            // Read data is taken at the closing rise
            if (!cur_q.write) begin
              rdata_d = data_s;
            end
            pins_d.rd_n                     = 1'b1;
            pins_d.low_byte_write_strobe_n  = 1'b1;
            pins_d.high_byte_write_strobe_n = 1'b1;
            pins_d.area_selects_n           = '1;
            pins_d.data_oe_n                = 1'b1;
            done_d                          = 1'b1;
            ready_d                         = 1'b1;
            state_d                         = ST_IDLE;
          end else if (cnt_q < len_q) begin
            // Each wait holds the strobe one more period
            cnt_d = cnt_q + 3'h1; // R14
          end
        end
      end
      // Illegal state code: recover to idle
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // Register all state; reset leaves the bus idle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      bclk_prev_q <= 1'b0;
      // Wait controls cleared: no-wait memory, one-wait areas
      cfg_q.internal_wait_select    <= `EB_RST_IWS; // R11
      cfg_q.register_cycle_select   <= `EB_RST_RCS;
      cfg_q.multiplexed_mode        <= 1'b0;
      cfg_q.strobe_scheme_select    <= 1'b0;
      cfg_q.chip_select_control_reg <= `EB_RST_WAIT_DIS; // R11
      cfg_q.wait_expansion_reg      <= `EB_RST_WAIT_EXP; // R11
      cur_q       <= '0;
      cnt_q       <= 3'h0;
      len_q       <= 3'h0;
      rdy_use_q   <= 1'b0;
      // Pins idle: strobes and selects high, data floating
      pins_q.addr                     <= '0;
      pins_q.data                     <= '0;
      pins_q.data_oe_n                <= 1'b1;
      pins_q.rd_n                     <= 1'b1;
      pins_q.low_byte_write_strobe_n  <= 1'b1;
      pins_q.high_byte_write_strobe_n <= 1'b1;
      pins_q.byte_high_enable_n       <= 1'b1;
      pins_q.area_selects_n           <= '1;
      pins_q.ale                      <= 1'b0;
      ready_q     <= 1'b1;
      done_q      <= 1'b0;
      rdata_q     <= '0;
    end else begin
      // Normal operation: take every next value
      state_q     <= state_d;
      bclk_prev_q <= bclk_prev_d;
      cfg_q       <= cfg_d;
      cur_q       <= cur_d;
      cnt_q       <= cnt_d;
      len_q       <= len_d;
      rdy_use_q   <= rdy_use_d;
      pins_q      <= pins_d;
      ready_q     <= ready_d;
      done_q      <= done_d;
      rdata_q     <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign cfg_out   = cfg_q;
  assign req_ready = ready_q;
  assign done      = done_q;
  assign rdata     = rdata_q;
  assign pins      = pins_q;

endmodule : external_bus_wait_control

`default_nettype wire

// ---- tb/ext_bus_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// Ties the pin behaviour to the access that was taken
module ext_bus_checker
  import ext_bus_pkg::*;
(
  // Clock and reset
  input wire logic      clk_sys,
  input wire logic      sys_rst,
  // Request side
  input wire logic      req_valid,
  input wire bus_req_s  req,
  input wire logic      req_ready,
  input wire logic      done,
  // Observed outputs
  input wire wait_cfg_s cfg_out,
  input wire bus_pins_s pins
);
  logic     busy_d;  // Next busy flag
  logic     busy_q;  // Access in flight
  bus_req_s held_d;  // Next held request
  bus_req_s held_q;  // Request being served

  // Captures the request at the take, clears busy after done
  always_comb begin
    busy_d = busy_q;
    held_d = held_q;
    if (req_valid && req_ready) begin
      busy_d = 1'b1;
      held_d = req;
    end else if (done) begin
      busy_d = 1'b0;
    end
  end

  // Registers the tracking state
  always_ff @(posedge clk_sys) begin
    busy_q <= sys_rst ? 1'b0 : busy_d;
    held_q <= held_d;
  end

  wire logic is_mem = busy_q && held_q.area == AREA_MEM;  // Internal memory access
  wire logic is_sfr = busy_q && held_q.area == AREA_SFR;  // Register access
  wire logic is_ext = busy_q && held_q.area == AREA_EXT;  // External area access

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // End of an active read strobe
  sequence strobe_end_s;
    $rose(pins.rd_n);
  endsequence

  mem_strobes_a: assert property (
    is_mem |-> pins.rd_n && pins.low_byte_write_strobe_n && pins.high_byte_write_strobe_n)
    else $error("strobe active on internal memory access");
  sfr_selects_a: assert property (
    (is_mem || is_sfr) |-> pins.area_selects_n == 4'hF && !pins.ale)
    else $error("select or latch active on internal access");
  mem_hold_a: assert property (
    is_mem |-> $stable(pins.addr) && $stable(pins.byte_high_enable_n))
    else $error("address or byte-high moved on internal memory access");
  read_float_a: assert property (
    (is_mem || is_sfr) && !held_q.write |-> pins.data_oe_n)
    else $error("data driven on internal read");
  sfr_wdata_a: assert property (
    is_sfr && !pins.low_byte_write_strobe_n |-> !pins.data_oe_n && pins.data == held_q.wdata)
    else $error("register write data not on pins");
  strobe_end_a: assert property (
    strobe_end_s |-> done)
    else $error("read strobe ended without done");
  ext_select_a: assert property (
    is_ext && !pins.rd_n |-> pins.area_selects_n == ~(4'h1 << held_q.ext_sel))
    else $error("wrong chip select during external read");
  write_strobes_a: assert property (
    (is_ext || is_sfr) && held_q.write && !pins.low_byte_write_strobe_n |->
      pins.high_byte_write_strobe_n == !(cfg_out.strobe_scheme_select && held_q.byte_high))
    else $error("high write strobe disagrees with strobe scheme");
  reset_values_a: assert property (
    disable iff (1'b0) sys_rst |=> cfg_out == '0 && req_ready && !done && pins.area_selects_n == 4'hF)
    else $error("wait controls not cleared by reset");

endmodule : ext_bus_checker

bind external_bus_wait_control ext_bus_checker u_chk (
  .clk_sys   (clk_sys),
  .sys_rst   (sys_rst),
  .req_valid (req_valid),
  .req       (req),
  .req_ready (req_ready),
  .done      (done),
  .cfg_out   (cfg_out),
  .pins      (pins)
);

`default_nettype wire

// ---- tb/ext_bus_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.svh"

// External memory on the chip-select areas, with a commanded wait request
module ext_bus_partner
  import ext_bus_pkg::*;
(
  // Clocks
  input  wire logic                 clk_sys,
  input  wire logic                 bclk_pin,
  // Pins from the block
  input  wire bus_pins_s            pins,
  // Bus-clock rises to hold the wait request per access
  input  wire logic [3:0]           stall_rises,
  // Pins back to the block
  output logic [`EB_DATA_W-1:0]     data_pin_in,
  output logic                      wait_req_n_pin
);
  logic [3:0] rises_q;                                 // Rises seen while selected
  wire logic  sel = pins.area_selects_n != 4'hF;       // Some area selected

  initial begin
    data_pin_in    = '0;
    wait_req_n_pin = 1'b1;
    rises_q        = 4'h0;
  end

  // Counts bus-clock rises within one selected access
  always @(posedge bclk_pin) rises_q <= sel ? rises_q + 4'h1 : 4'h0;

  // Wait request changes mid-period so it is settled at the next rise
  always @(negedge bclk_pin) wait_req_n_pin <= !(sel && rises_q < stall_rises);

  // Answers reads from the address, otherwise the lines keep flipping
  always @(posedge clk_sys)
    data_pin_in <= (sel && !pins.rd_n) ? pins.addr[15:0] ^ 16'h5A5A : ~data_pin_in;

endmodule : ext_bus_partner

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.svh"

// Self-checking bench for the bus wait controller
module tb;
  import ext_bus_pkg::*;

  logic                  clk_sys = 1'b0;     // System clock
  logic                  sys_rst = 1'b1;     // Synchronous reset
  logic                  bclk_pin = 1'b0;    // Bus clock from outside
  logic                  cfg_load = 1'b0;    // Configuration strobe
  wait_cfg_s             cfg_in = '0;        // Configuration to load
  logic                  req_valid = 1'b0;   // Request present
  bus_req_s              req = '0;           // Request fields
  logic [3:0]            stall_rises = 4'h0; // Commanded wait length
  logic                  scheme = 1'b0;      // Strobe scheme to load
  wait_cfg_s             cfg_out;            // Current wait controls
  logic                  req_ready;          // Idle
  logic                  done;               // End of access
  logic [`EB_DATA_W-1:0] rdata;              // Read result
  logic [`EB_DATA_W-1:0] data_pin_in;        // Data lines in
  logic                  wait_req_n_pin;     // Wait request in
  bus_pins_s             pins;               // Pin outputs
  int                    mismatches = 0;     // Failed comparisons
  int                    n_compared = 0;     // All comparisons
  int                    rises = 0;          // Bus-clock rises since take
  int                    n;                  // Rises seen by one access
  // Row: area[11:10] write[9] iws[8] rcs[7] mux[6] wait_disable[5] expansion[4:3] length[2:0]
  logic [11:0] rows [14] = '{12'h002, 12'h283, 12'h401, 12'h702, 12'h821, 12'hA22, 12'h922,
                             12'h802, 12'h80B, 12'h814, 12'hA43, 12'h84B, 12'h854, 12'h943};

  always #5 clk_sys = ~clk_sys;
  always @(posedge bclk_pin) rises = rises + 1;

  // Bus clock at 125 ns, phase unrelated to the system clock
  initial begin
    #3.3;
    forever #62.5 bclk_pin = ~bclk_pin;
  end

  external_bus_wait_control u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_out(cfg_out),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done), .rdata(rdata),
    .bclk_pin(bclk_pin), .wait_req_n_pin(wait_req_n_pin), .data_pin_in(data_pin_in), .pins(pins));

  ext_bus_partner u_far (
    .clk_sys(clk_sys), .bclk_pin(bclk_pin), .pins(pins), .stall_rises(stall_rises),
    .data_pin_in(data_pin_in), .wait_req_n_pin(wait_req_n_pin));

  // Compares one value and counts it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then stops
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Loads the row's controls, requests clear of a bus-clock edge, counts rises to done
  task automatic access(input logic [11:0] row, input logic [1:0] sel, input logic bh, output int cnt);
    int guard;
    @(posedge clk_sys);
    #1;
    cfg_in   = {row[8], row[7], row[6], scheme, {4{row[5]}}, {4{row[4:3]}}};
    cfg_load = 1'b1;
    @(posedge clk_sys);
    #1;
    cfg_load = 1'b0;
    @(posedge bclk_pin);
    repeat (4) @(posedge clk_sys);
    #1;
    req.area      = area_e'({1'b0, row[11:10]});
    req.ext_sel   = sel;
    req.write     = row[9];
    req.byte_high = bh;
    req.addr      = {16'h0ACE, 2'h0, sel};
    req.wdata     = 16'hC3A5;
    req_valid     = 1'b1;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    rises     = 0;
    guard     = 0;
    while (done !== 1'b1 && guard < 400) begin
      @(posedge clk_sys);
      #1;
      guard++;
    end
    if (guard >= 400) mismatches++;
    cnt = rises;
  endtask : access

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    // Table of cycle lengths for every area and mode, field codes 00 to 10
    for (int i = 0; i < 14; i++) begin
      access(rows[i], i[1:0], 1'b1, n);
      check("bus clocks", n, rows[i][2:0] + 1);
      if (rows[i][11:9] == 3'h4 && !rows[i][6])
        check("read data", rdata, {12'hACE, 2'h0, i[1:0]} ^ 16'h5A5A);
    end
    // Wait request honoured with waits enabled, ignored without
    stall_rises = 4'h4;
    access(12'h802, 2'h3, 1'b1, n);
    check("waited clocks", n, 6);
    access(12'h821, 2'h2, 1'b1, n);
    check("unwaited clocks", n, 2);
    stall_rises = 4'h0;
    // Split write strobes: the high strobe follows byte-high
    scheme = 1'b1;
    access(12'hA22, 2'h0, 1'b1, n);
    check("split strobe clocks", n, 3);
    scheme = 1'b0;
    // Internal memory keeps the register access's address and byte-high
    access(12'h283, 2'h1, 1'b1, n);
    access(12'h702, 2'h2, 1'b0, n);
    check("held address", pins.addr, 20'h0ACE1);
    check("held byte-high", pins.byte_high_enable_n, 1'b0);
    check("data floating", pins.data_oe_n, 1'b1);
    // Reset in mid-run clears the wait controls
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    check("controls cleared", cfg_out, 16'h0);
    check("selects idle", pins.area_selects_n, 4'hF);
    check("latch idle", pins.ale, 1'b0);
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    check("ready after reset", req_ready, 1'b1);
    access(12'h802, 2'h0, 1'b0, n);
    check("clocks after reset", n, 3);
    complete_run();
  end

  // Cuts a hang short
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

endmodule : tb

`default_nettype wire
